// ---- ccf_cond_eval.sv ----
// combinational condition decoder: 4-bit field and flags to a decision
// assumes flags come straight from the flag register
`timescale 1ns/1ps
module ccf_cond_eval
    import ccf_pkg::*;
(
    input wire logic [3:0] cc_i, // condition field
    input wire logic flag_c_i, // carry
    input wire logic flag_z_i, // zero
    input wire logic flag_s_i, // sign
    input wire logic flag_v_i, // overflow
    output logic taken_o // branch decision
);
    // signed-less term shared by several codes
    wire logic s_xor_v = flag_s_i ^ flag_v_i;
    wire logic le_term = flag_z_i | s_xor_v;
    wire logic at_most_term = flag_c_i | flag_z_i;
    // decode of the field
    always_comb
    begin
        case (cc_i)
            CCF_CC_NEVER: taken_o = 1'b0;
            CCF_CC_ALWAYS: taken_o = 1'b1;
            CCF_CC_UNSIGNED_BELOW: taken_o = flag_c_i;
            CCF_CC_UNSIGNED_NOT_BELOW: taken_o = ~flag_c_i;
            CCF_CC_EQ: taken_o = flag_z_i;
            CCF_CC_NE: taken_o = ~flag_z_i;
            CCF_CC_PL: taken_o = ~flag_s_i;
            CCF_CC_MI: taken_o = flag_s_i;
            CCF_CC_OV: taken_o = flag_v_i;
            CCF_CC_NO_SIGNED_WRAP: taken_o = ~flag_v_i;
            CCF_CC_GE: taken_o = ~s_xor_v;
            CCF_CC_LT: taken_o = s_xor_v;
            CCF_CC_GT: taken_o = ~le_term;
            CCF_CC_LE: taken_o = le_term;
            CCF_CC_UNSIGNED_ABOVE: taken_o = ~at_most_term;
            CCF_CC_UNSIGNED_AT_MOST: taken_o = at_most_term;
            default: taken_o = 1'b0;
        endcase
    end
endmodule

// ---- ccf_flag_update.sv ----
// per-flag next-value logic: keep, clear, set, compute or undefined
// assumes the sequencer supplies a 3-bit mode and a computed bit per flag
`timescale 1ns/1ps
module ccf_flag_update
    import ccf_pkg::*;
#(
    parameter int NFLAG = 6 // number of condition flags
)
(
    input wire logic [NFLAG-1:0] cur_i, // stored flags
    input wire logic [3*NFLAG-1:0] mode_i, // packed update modes
    input wire logic [NFLAG-1:0] calc_i, // alu computed values
    output logic [NFLAG-1:0] next_o // next flag values
);
    genvar gi;
    // one selector per flag
    generate
        for (gi = 0; gi < NFLAG; gi++)
        begin : g_flag
            wire logic [2:0] m = mode_i[3*gi +: 3];
            // undefined keeps the old value, which is one legal outcome
            assign next_o[gi] = (m == CCF_UPD_CLR) ? 1'b0 :
                (m == CCF_UPD_SET) ? 1'b1 :
                (m == CCF_UPD_CALC) ? calc_i[gi] :
                cur_i[gi];
        end
    endgenerate
endmodule

// ---- ccf_pkg.sv ----
// package for the condition flag block: register map, flag fields, codes
// assumes a single 100 MHz clock and an avalon-mm byte-addressed slave
package ccf_pkg;
    // byte address of the flag register (control register 252)
    localparam logic [7:0] CCF_FLAG_OFS = 8'hfc;
    // status/id register of the block
    localparam logic [7:0] CCF_STAT_OFS = 8'hf0;
    // flag bit positions inside the flag register
    localparam int CCF_BIT_C = 7;
    localparam int CCF_BIT_Z = 6;
    localparam int CCF_BIT_S = 5;
    localparam int CCF_BIT_V = 4;
    localparam int CCF_BIT_D = 3;
    localparam int CCF_BIT_H = 2;
    // reset value of the flag register
    localparam logic [7:0] CCF_FLAG_RST = 8'h00;
    // implemented flag bits; bits 1:0 hold user bits without meaning here
    localparam logic [7:0] CCF_FLAG_MASK = 8'hff;
    // per-flag update modes requested by the sequencer
    localparam logic [2:0] CCF_UPD_KEEP = 3'h0;
    localparam logic [2:0] CCF_UPD_CLR = 3'h1;
    localparam logic [2:0] CCF_UPD_SET = 3'h2;
    localparam logic [2:0] CCF_UPD_CALC = 3'h3;
    localparam logic [2:0] CCF_UPD_UNDEF = 3'h4;
    // condition field encodings
    localparam logic [3:0] CCF_CC_NEVER = 4'h0;
    localparam logic [3:0] CCF_CC_LT = 4'h1;
    localparam logic [3:0] CCF_CC_LE = 4'h2;
    localparam logic [3:0] CCF_CC_UNSIGNED_AT_MOST = 4'h3;
    localparam logic [3:0] CCF_CC_OV = 4'h4;
    localparam logic [3:0] CCF_CC_MI = 4'h5;
    localparam logic [3:0] CCF_CC_EQ = 4'h6;
    localparam logic [3:0] CCF_CC_UNSIGNED_BELOW = 4'h7;
    localparam logic [3:0] CCF_CC_ALWAYS = 4'h8;
    localparam logic [3:0] CCF_CC_GE = 4'h9;
    localparam logic [3:0] CCF_CC_GT = 4'ha;
    localparam logic [3:0] CCF_CC_UNSIGNED_ABOVE = 4'hb;
    localparam logic [3:0] CCF_CC_NO_SIGNED_WRAP = 4'hc;
    localparam logic [3:0] CCF_CC_PL = 4'hd;
    localparam logic [3:0] CCF_CC_NE = 4'he;
    localparam logic [3:0] CCF_CC_UNSIGNED_NOT_BELOW = 4'hf;
    // bus slave states
    typedef enum logic [2:0]
    {
        CCF_BUS_IDLE = 3'b001,
        CCF_BUS_ACK = 3'b010,
        CCF_BUS_HOLD = 3'b100
    } ccf_bus_state_t;
endpackage

// ---- ccf_seq_model.sv ----
// sequencer and alu stand-in: drives flag updates and condition fields
// assumes the bench calls its tasks from one process at a time
`timescale 1ns/1ps
module ccf_seq_model
(
    input wire logic clk_sys_i, // system clock
    output logic upd_valid_o, // flag update strobe
    output logic [17:0] upd_mode_o, // per-flag update modes
    output logic [5:0] upd_calc_o, // computed flag values
    output logic [3:0] cc_o // condition field of the branch
);
    // idle values at time zero
    initial
    begin
        upd_valid_o = 1'b0;
        upd_mode_o = 18'h00000;
        upd_calc_o = 6'h00;
        cc_o = 4'h0;
    end
    // one-cycle update; released lines flip so stale values never look valid
    task automatic apply(input logic [17:0] m, input logic [5:0] v);
        @(posedge clk_sys_i);
        upd_mode_o <= m;
        upd_calc_o <= v;
        upd_valid_o <= 1'b1;
        @(posedge clk_sys_i);
        upd_valid_o <= 1'b0;
        upd_mode_o <= ~m;
        upd_calc_o <= ~v;
    endtask
    // present a condition field for one full cycle
    task automatic ask(input logic [3:0] c);
        @(posedge clk_sys_i);
        cc_o <= c;
        @(posedge clk_sys_i);
    endtask
endmodule

// ---- ccf_top.sv ----
// condition flag register with avalon-mm access and branch decision
// assumes sequencer and alu on clk_sys_i, synchronous reset, and one
// bus master obeying waitrequest
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ps
// Function
// - six flags held in register 252
// - software reads and writes the flag register
// - per-instruction flag clear/set/compute/keep/undefined
// - field 0111 true when carry set
// - field 1111 true when carry clear
// - 0110 zero set, 1110 zero clear
// - 1101 sign clear, 0101 sign set
// - 0100 overflow set, 1100 overflow clear
// - 1001 S xor V clear, 0001 set
// - 1010 Z or (S xor V) clear, 0010 set
// - 1011 C,Z clear; 0011 C or Z
module ccf_top
    import ccf_pkg::*;
#(
    parameter int AW = 8 // avalon byte address width
)
(
    input wire logic clk_sys_i, // 100 MHz system clock
    input wire logic rst_i, // synchronous reset, active high
    input wire logic ce_i, // clock enable, freezes all state when low
    // avalon-mm slave
    input wire logic [AW-1:0] avs_address_i, // byte address
    input wire logic avs_read_i, // read request
    input wire logic avs_write_i, // write request
    input wire logic [31:0] avs_writedata_i, // write data
    input wire logic [3:0] avs_byteenable_i, // byte lanes
    output logic [31:0] avs_readdata_o, // read data
    output logic avs_waitrequest_o, // stall
    output logic [1:0] avs_response_o, // 00 okay, 10 slave error
    // sequencer / alu side
    input wire logic upd_valid_i, // apply flag update this cycle
    input wire logic [17:0] upd_mode_i, // 3 bits per flag C,Z,S,V,D,H
    input wire logic [5:0] upd_calc_i, // computed flag values C..H
    input wire logic [3:0] cc_i, // condition field of the branch
    output logic cc_true_o, // branch decision
    output logic [7:0] flags_o // current flag register
);
    import ccf_pkg::*;

    // flag register storage
    logic [7:0] flag_reg;
    // bus state and registered read data
    ccf_bus_state_t bus_state;
    ccf_bus_state_t next_bus_state;
    logic [31:0] rdata;
    logic [1:0] resp;

    // decodes
    wire logic req = avs_read_i | avs_write_i;
    wire logic hit_flag = (avs_address_i == AW'(CCF_FLAG_OFS));
    wire logic hit_stat = (avs_address_i == AW'(CCF_STAT_OFS));
    wire logic hit_any = hit_flag | hit_stat;
    // word chosen at acceptance; only lane 0 carries flags
    wire logic [31:0] rd_word = hit_flag ? {24'h00_0000, flag_reg} : 32'h0000_0000;
    // unmapped places answer a slave error
    wire logic [1:0] rsp_code = hit_any ? 2'h0 : 2'h2;
    wire logic accept = ce_i & (bus_state == CCF_BUS_IDLE) & req;
    wire logic wr_flag = accept & avs_write_i & hit_flag & avs_byteenable_i[0];
    wire logic [5:0] cur6 = flag_reg[7:2];
    wire logic [5:0] upd6;
    wire logic [7:0] flag_after_upd = {upd6, flag_reg[1:0]};
    wire logic [7:0] next_flag = wr_flag ? (avs_writedata_i[7:0] & CCF_FLAG_MASK)
        : (upd_valid_i ? flag_after_upd : flag_reg);

    // per-flag update selectors
    ccf_flag_update #(.NFLAG(6)) u_upd
    (
        .cur_i(cur6),
        .mode_i(upd_mode_i),
        .calc_i(upd_calc_i),
        .next_o(upd6)
    );

    // branch decision from the stored flags
    ccf_cond_eval u_eval
    (
        .cc_i(cc_i),
        .flag_c_i(flag_reg[CCF_BIT_C]),
        .flag_z_i(flag_reg[CCF_BIT_Z]),
        .flag_s_i(flag_reg[CCF_BIT_S]),
        .flag_v_i(flag_reg[CCF_BIT_V]),
        .taken_o(cc_true_o)
    );

    // flag register; software write beats an alu update in the same cycle
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            flag_reg <= CCF_FLAG_RST;
        else if (ce_i)
            flag_reg <= next_flag;
    end

    // bus state sequencing: accept, answer, then one hold cycle
    always_comb
    begin
        case (bus_state)
            CCF_BUS_IDLE: next_bus_state = accept ? CCF_BUS_ACK : CCF_BUS_IDLE;
            CCF_BUS_ACK: next_bus_state = CCF_BUS_HOLD;
            CCF_BUS_HOLD: next_bus_state = CCF_BUS_IDLE;
            default: next_bus_state = CCF_BUS_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
            bus_state <= CCF_BUS_IDLE;
        else if (ce_i)
            bus_state <= next_bus_state;
    end

    // read data captured at acceptance; unmapped answers slave error
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            rdata <= 32'h0000_0000;
            resp <= 2'h0;
        end
        else if (accept)
        begin
            rdata <= rd_word;
            resp <= rsp_code;
        end
    end

    // waitrequest low only in the answer cycle
    assign avs_waitrequest_o = (bus_state != CCF_BUS_ACK);
    assign avs_readdata_o = rdata;
    assign avs_response_o = resp;
    assign flags_o = flag_reg;

    // checks

    // an accepted flag write lands at its own edge
    AST_WR_FLAG: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        wr_flag |=> flag_reg == $past(avs_writedata_i[7:0]))
        else $error("flag write not stored");

    // read data stand in the answer cycle
    AST_READ_FLAG: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (accept && avs_read_i && hit_flag) |=> (avs_readdata_o[7:0] == $past(flag_reg)
        && !avs_waitrequest_o))
        else $error("flag read wrong");

    // clear mode on carry
    AST_UPD_CLR: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && upd_valid_i && !wr_flag && upd_mode_i[17:15] == CCF_UPD_CLR)
        |=> !flag_reg[CCF_BIT_C])
        else $error("carry clear failed");

    // keep mode on zero
    AST_UPD_KEEP: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && upd_valid_i && !wr_flag && upd_mode_i[14:12] == CCF_UPD_KEEP)
        |=> $stable(flag_reg[CCF_BIT_Z]))
        else $error("zero flag changed on keep");

    // carry set test
    AST_CC_CARRY: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (cc_i == CCF_CC_UNSIGNED_BELOW) |-> cc_true_o == flag_reg[CCF_BIT_C])
        else $error("carry test wrong");

    // carry clear test
    AST_CC_NOCARRY: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (cc_i == CCF_CC_UNSIGNED_NOT_BELOW) |-> cc_true_o != flag_reg[CCF_BIT_C])
        else $error("no-carry test wrong");

    // zero tests, bit 3 inverts
    AST_CC_ZERO: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (cc_i == CCF_CC_EQ || cc_i == CCF_CC_NE)
        |-> cc_true_o == (flag_reg[CCF_BIT_Z] ^ cc_i[3]))
        else $error("zero test wrong");

    // sign tests
    AST_CC_SIGN: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (cc_i == CCF_CC_MI || cc_i == CCF_CC_PL)
        |-> cc_true_o == (flag_reg[CCF_BIT_S] ^ cc_i[3]))
        else $error("sign test wrong");

    // overflow tests
    AST_CC_OVF: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (cc_i == CCF_CC_OV || cc_i == CCF_CC_NO_SIGNED_WRAP)
        |-> cc_true_o == (flag_reg[CCF_BIT_V] ^ cc_i[3]))
        else $error("overflow test wrong");

    // signed less and greater-or-equal
    AST_CC_LT: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (cc_i == CCF_CC_LT || cc_i == CCF_CC_GE)
        |-> cc_true_o == (flag_reg[CCF_BIT_S] ^ flag_reg[CCF_BIT_V] ^ cc_i[3]))
        else $error("signed less test wrong");

    // signed less-or-equal and greater
    AST_CC_LE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (cc_i == CCF_CC_LE || cc_i == CCF_CC_GT) |-> cc_true_o ==
        ((flag_reg[CCF_BIT_Z] | (flag_reg[CCF_BIT_S] ^ flag_reg[CCF_BIT_V])) ^ cc_i[3]))
        else $error("signed le test wrong");

    // unsigned at-most and above
    AST_CC_ULE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (cc_i == CCF_CC_UNSIGNED_AT_MOST || cc_i == CCF_CC_UNSIGNED_ABOVE)
        |-> cc_true_o == ((flag_reg[CCF_BIT_C] | flag_reg[CCF_BIT_Z]) ^ cc_i[3]))
        else $error("unsigned test wrong");

    // always and never
    AST_CC_CONST: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (cc_i == CCF_CC_ALWAYS || cc_i == CCF_CC_NEVER) |-> cc_true_o == cc_i[3])
        else $error("constant test wrong");

    // answer one cycle after acceptance, then a hold cycle
    AST_BUS_LAT: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (accept && ce_i) |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
        else $error("bus answer latency wrong");


    // flags frozen while the clock enable is low
    AST_CE_FREEZE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !ce_i
        |=> $stable(flags_o))
        else $error("flags moved with clock enable low");

    // reset leaves zero flags, a stalled bus and cleared answers
    AST_RST_STATE: assert property (@(posedge clk_sys_i)
        rst_i
        |=> (flags_o == CCF_FLAG_RST) && avs_waitrequest_o
        && (avs_readdata_o == 32'h0000_0000) && (avs_response_o == 2'h0))
        else $error("reset state wrong");

    // a write with lane 0 off leaves the flags alone
    AST_LANE_OFF: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (accept && avs_write_i && hit_flag && !avs_byteenable_i[0] && !upd_valid_i)
        |=> $stable(flags_o))
        else $error("flags changed by a write with lane 0 off");

    // unmapped places answer a slave error and read zero
    AST_UNMAPPED: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (accept && !hit_any)
        |=> (avs_response_o == 2'h2) && (avs_readdata_o == 32'h0000_0000))
        else $error("unmapped answer wrong");

    // status place answers okay and reads zero
    AST_STAT_READ: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (accept && hit_stat)
        |=> (avs_response_o == 2'h0) && (avs_readdata_o == 32'h0000_0000))
        else $error("status read wrong");

    // software write wins over an alu update in the same cycle
    AST_SW_WINS: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (wr_flag && upd_valid_i)
        |=> flags_o == $past(avs_writedata_i[7:0]))
        else $error("alu update beat a software write");

    // set mode on carry
    AST_UPD_SET: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && upd_valid_i && !wr_flag && upd_mode_i[17:15] == CCF_UPD_SET)
        |=> flags_o[CCF_BIT_C])
        else $error("carry set failed");

    // compute mode on sign takes the alu bit
    AST_UPD_CALC: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && upd_valid_i && !wr_flag && upd_mode_i[11:9] == CCF_UPD_CALC)
        |=> flags_o[CCF_BIT_S] == $past(upd_calc_i[3]))
        else $error("sign compute failed");

    // read data and response stand until the next acceptance
    AST_RD_STANDS: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !accept
        |=> $stable(avs_readdata_o) && $stable(avs_response_o))
        else $error("bus answer changed without a request");

    // waitrequest low for one cycle only
    AST_WAIT_ONE: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (!avs_waitrequest_o && ce_i)
        |=> avs_waitrequest_o)
        else $error("waitrequest low too long");

    // main scenarios
    COV_WRITE: cover property (@(posedge clk_sys_i) disable iff (rst_i) wr_flag);
    COV_READ: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        accept && avs_read_i && hit_flag);
    COV_UPD: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        ce_i && upd_valid_i);
    COV_TAKEN: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        cc_true_o && cc_i == CCF_CC_GT);
    COV_CE_LOW: cover property (@(posedge clk_sys_i) disable iff (rst_i)
        !ce_i && upd_valid_i);
endmodule

// ---- condition_code_flag_eval_tb.sv ----
// self-checking bench for the flag register and branch decision
// assumes the sequencer model file and the design package are compiled first
`timescale 1ns/1ps
`define CHK(nm, e, g) \
    begin checks_done++; if ((g) !== (e)) begin bad_count++; \
    $display("unexpected %s expected %0h seen %0h", nm, e, g); end end
module condition_code_flag_eval_tb;
    import ccf_pkg::*;
    logic clk_sys_i; // system clock
    logic rst_i; // synchronous reset
    logic ce_i; // clock enable
    logic [7:0] avs_address_i; // bus address
    logic avs_read_i; // bus read
    logic avs_write_i; // bus write
    logic [31:0] avs_writedata_i; // bus write data
    logic [3:0] avs_byteenable_i; // byte lanes
    logic [31:0] avs_readdata_o; // bus read data
    logic avs_waitrequest_o; // bus stall
    logic [1:0] avs_response_o; // bus response
    logic upd_valid_i; // update strobe from model
    logic [17:0] upd_mode_i; // update modes from model
    logic [5:0] upd_calc_i; // computed flags from model
    logic [3:0] cc_i; // condition field from model
    logic cc_true_o; // branch decision
    logic [7:0] flags_o; // flag register
    int bad_count = 0; // mismatches
    int checks_done = 0; // comparisons
    // design under test
    ccf_top DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .avs_response_o(avs_response_o),
        .upd_valid_i(upd_valid_i), .upd_mode_i(upd_mode_i), .upd_calc_i(upd_calc_i),
        .cc_i(cc_i), .cc_true_o(cc_true_o), .flags_o(flags_o));
    // sequencer and alu stand-in
    ccf_seq_model model (.clk_sys_i(clk_sys_i), .upd_valid_o(upd_valid_i),
        .upd_mode_o(upd_mode_i), .upd_calc_o(upd_calc_i), .cc_o(cc_i));
    // 100 MHz clock
    initial
    begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    // verdict and end of run
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // one bus transfer; request held until waitrequest is seen low at an edge
    task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        input logic [3:0] be, output logic [31:0] rd, output logic [1:0] rs);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        avs_address_i <= a;
        avs_writedata_i <= wd;
        avs_byteenable_i <= be;
        avs_write_i <= wr;
        avs_read_i <= ~wr;
        @(posedge clk_sys_i);
        while (avs_waitrequest_o !== 1'b0 && n < 100)
        begin
            @(posedge clk_sys_i);
            n++;
        end
        if (n >= 100)
            bad_count++;
        rd = avs_readdata_o;
        rs = avs_response_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        avs_writedata_i <= ~wd;
    endtask
    // reset state, write/read back, lane refusal, reserved and unmapped places
    task automatic bus_scenario();
        logic [31:0] d;
        logic [1:0] r;
        `CHK("flags_o at reset", 8'h00, flags_o)
        `CHK("waitrequest at reset", 1'b1, avs_waitrequest_o)
        `CHK("readdata at reset", 32'h0, avs_readdata_o)
        bus_xfer(1'b0, CCF_FLAG_OFS, 32'h0, 4'hf, d, r);
        `CHK("flag read at reset", 32'h0, d)
        bus_xfer(1'b1, CCF_FLAG_OFS, 32'hffff_ffa5, 4'hf, d, r);
        bus_xfer(1'b0, CCF_FLAG_OFS, 32'h0, 4'hf, d, r);
        `CHK("flag readback", 32'h0000_00a5, d)
        `CHK("flag read response", 2'b00, r)
        bus_xfer(1'b1, CCF_FLAG_OFS, 32'h0000_003c, 4'he, d, r);
        `CHK("flags_o after lane0 off", 8'ha5, flags_o)
        bus_xfer(1'b1, 8'h10, 32'h0000_0011, 4'hf, d, r);
        `CHK("unmapped write response", 2'b10, r)
        `CHK("flags_o after unmapped write", 8'ha5, flags_o)
        bus_xfer(1'b0, 8'h10, 32'h0, 4'hf, d, r);
        `CHK("unmapped read data", 32'h0, d)
        bus_xfer(1'b0, CCF_STAT_OFS, 32'h0, 4'hf, d, r);
        `CHK("reserved read data", 32'h0, d)
        `CHK("reserved read response", 2'b00, r)
    endtask
    // clear, set, compute, keep and undefined modes in one update
    task automatic update_scenario();
        logic [31:0] d;
        logic [1:0] r;
        bus_xfer(1'b1, CCF_FLAG_OFS, 32'h0000_005c, 4'hf, d, r);
        model.apply({CCF_UPD_SET, CCF_UPD_CLR, CCF_UPD_CALC, CCF_UPD_KEEP,
            CCF_UPD_UNDEF, CCF_UPD_CALC}, 6'b011000);
        #1;
        `CHK("flags_o after mixed update", 8'hb8, flags_o)
        model.apply({6{CCF_UPD_KEEP}}, 6'h3f);
        #1;
        `CHK("flags_o after keep update", 8'hb8, flags_o)
        model.apply({6{CCF_UPD_CALC}}, 6'b100101);
        #1;
        `CHK("flags_o after compute update", 8'h94, flags_o)
        model.apply({6{CCF_UPD_CLR}}, 6'h3f);
        #1;
        `CHK("flags_o after clear update", 8'h00, flags_o)
    endtask
    // clock enable freeze, write against update, unmapped answer, mid-run reset
    task automatic ctrl_scenario();
        logic [31:0] d;
        logic [1:0] r;
        bus_xfer(1'b1, CCF_FLAG_OFS, 32'h0000_0040, 4'h1, d, r);
        @(posedge clk_sys_i);
        ce_i <= 1'b0;
        model.apply({6{CCF_UPD_SET}}, 6'h00);
        #1;
        `CHK("flags_o with ce low", 8'h40, flags_o)
        @(posedge clk_sys_i);
        ce_i <= 1'b1;
        fork
            bus_xfer(1'b1, CCF_FLAG_OFS, 32'h0000_000c, 4'h1, d, r);
            model.apply({6{CCF_UPD_SET}}, 6'h00);
        join
        #1;
        `CHK("flags_o write beats update", 8'h0c, flags_o)
        bus_xfer(1'b0, 8'h10, 32'h0, 4'hf, d, r);
        `CHK("unmapped read response", 2'b10, r)
        @(posedge clk_sys_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        #1;
        `CHK("flags_o after reset", 8'h00, flags_o)
        `CHK("response after reset", 2'b00, avs_response_o)
        `CHK("waitrequest after reset", 1'b1, avs_waitrequest_o)
        bus_xfer(1'b0, CCF_FLAG_OFS, 32'h0, 4'hf, d, r);
        `CHK("flag read after reset", 32'h0, d)
    endtask
    // reference decision for a condition field
    function automatic logic cond_ref(input logic [3:0] cc, input logic c, input logic z,
        input logic s, input logic v);
        case (cc)
            4'h0: return 1'b0;
            4'h1: return s ^ v;
            4'h2: return z | (s ^ v);
            4'h3: return c | z;
            4'h4: return v;
            4'h5: return s;
            4'h6: return z;
            4'h7: return c;
            4'h8: return 1'b1;
            4'h9: return ~(s ^ v);
            4'ha: return ~(z | (s ^ v));
            4'hb: return ~c & ~z;
            4'hc: return ~v;
            4'hd: return ~s;
            4'he: return ~z;
            default: return ~c;
        endcase
    endfunction
    // every field against every carry, zero, sign and overflow combination
    task automatic cond_scenario();
        logic [31:0] d;
        logic [1:0] r;
        logic [7:0] f;
        logic e;
        for (int k = 0; k < 16; k++)
        begin
            f = 8'h0c;
            f[CCF_BIT_C] = k[3];
            f[CCF_BIT_Z] = k[2];
            f[CCF_BIT_S] = k[1];
            f[CCF_BIT_V] = k[0];
            bus_xfer(1'b1, CCF_FLAG_OFS, {24'h0, f}, 4'h1, d, r);
            for (int c = 0; c < 16; c++)
            begin
                model.ask(c[3:0]);
                #1;
                e = cond_ref(c[3:0], k[3], k[2], k[1], k[0]);
                case (c[2:0])
                    3'h0: `CHK("cc_true_o", e, cc_true_o)
                    3'h1: `CHK("cc_true_o", e, cc_true_o)
                    3'h2: `CHK("cc_true_o", e, cc_true_o)
                    3'h3: `CHK("cc_true_o", e, cc_true_o)
                    3'h4: `CHK("cc_true_o", e, cc_true_o)
                    3'h5: `CHK("cc_true_o", e, cc_true_o)
                    3'h6: `CHK("cc_true_o", e, cc_true_o)
                    default: `CHK("cc_true_o", e, cc_true_o)
                endcase
            end
        end
    endtask
    // watchdog well beyond the expected run length
    initial
    begin
        #200000;
        bad_count++;
        complete_run();
    end
    // main sequence
    initial
    begin
        rst_i = 1'b1;
        ce_i = 1'b1;
        avs_address_i = 8'h00;
        avs_read_i = 1'b0;
        avs_write_i = 1'b0;
        avs_writedata_i = 32'h0;
        avs_byteenable_i = 4'h0;
        repeat (4) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        #1;
        bus_scenario();
        update_scenario();
        cond_scenario();
        ctrl_scenario();
        complete_run();
    end
endmodule
